// ### design/gprc_pkg.sv
package gprc_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned RSV_BIT   = 6;
  localparam int unsigned KIND_W    = 2;
  localparam int unsigned PAYLOAD_W = KIND_W + 1 + BYTE_W;
  localparam int unsigned IFC_CNT_W = 16;

  // ----------------------------------------------------------------
  // reset values and fixed bus codes
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RESP_DEFAULT    = 8'h00;
  localparam logic [BYTE_W-1:0] TIMEOUT_DEFAULT = 8'h0A;
  localparam logic [BYTE_W-1:0] UNTALK_CODE     = 8'h5F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned IFC_MIN_US  = 500;
  // least time: exact product, so no rounding is lost
  localparam int unsigned IFC_MIN_CYC = IFC_MIN_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [KIND_W-1:0] {
    KIND_CMD  = 2'b00,
    KIND_UNT  = 2'b01,
    KIND_DATA = 2'b10,
    KIND_EOI  = 2'b11
  } gprc_kind_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } gprc_tx_st_t;

  typedef struct packed {
    logic [BYTE_W-1:0]    resp;
    logic [BYTE_W-1:0]    timeout;
    logic                 flag_chg;
    logic                 flag_trg;
    logic                 flag_clr;
    logic                 ifc;
    logic [IFC_CNT_W-1:0] ifc_cnt;
    logic                 atn;
    logic                 eoi;
    gprc_tx_st_t          tx_st;
    gprc_kind_t           tx_kind;
    logic [BYTE_W-1:0]    dio;
    logic                 poll_drv;
    logic                 poll_s1;
    logic                 poll_s2;
    logic                 poll_prev;
    logic                 ack_s1;
    logic                 ack_s2;
    logic                 ack_prev;
    logic                 reject;
  } gprc_state_t;

endpackage : gprc_pkg

// ### design/gprc_buf2.sv
`timescale 1ns/100ps
`default_nettype none

module gprc_buf2 #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import gprc_pkg::*;

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } gprc_buf_state_t;

  gprc_buf_state_t q;
  gprc_buf_state_t d;
  logic            push;
  logic            pop;

  // two entries let the source keep going for two words while the drain stalls
  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : gprc_buf2

`default_nettype wire

// ### design/gprc_top.sv
`timescale 1ns/100ps
`default_nettype none

module gprc_top #(
  parameter int unsigned IFC_CYCLES = gprc_pkg::IFC_MIN_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // role configuration from host
  input  wire logic                          is_peripheral,
  input  wire logic                          is_sys_ctrl,
  input  wire logic                          is_active_ctrl,
  // poll response
  input  wire logic                          resp_load,
  input  wire logic [gprc_pkg::BYTE_W-1:0]   resp_value,
  output logic [gprc_pkg::BYTE_W-1:0]        poll_response_value,
  output logic                               rsv_status,
  // warm reset and defaults
  input  wire logic                          warm_reset,
  input  wire logic                          flag_change_set,
  input  wire logic                          flag_trigger_set,
  input  wire logic                          flag_clear_set,
  input  wire logic                          timeout_load,
  input  wire logic [gprc_pkg::BYTE_W-1:0]   timeout_value,
  output logic                               flag_change,
  output logic                               flag_trigger,
  output logic                               flag_clear,
  output logic [gprc_pkg::BYTE_W-1:0]        timeout_setting,
  output logic                               warm_busy,
  // command stream from host
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire gprc_pkg::gprc_kind_t          cmd_kind,
  input  wire logic [gprc_pkg::BYTE_W-1:0]   cmd_byte,
  input  wire logic                          cmd_last,
  input  wire logic                          resume_req,
  output logic                               op_reject,
  // bus lines, asserted high
  output logic                               ifc_out,
  output logic                               atn_out,
  output logic                               eoi_out,
  output logic                               srq_out,
  output logic                               dav_out,
  output logic [gprc_pkg::BYTE_W-1:0]        dio_out,
  output logic                               dio_oe,
  input  wire logic                          poll_read_pin,
  input  wire logic                          bus_ack_pin
);
  import gprc_pkg::*;

  localparam logic [IFC_CNT_W-1:0] IFC_LAST = IFC_CNT_W'(IFC_CYCLES - 1);

  gprc_state_t                q;
  gprc_state_t                d;
  logic                       poll_edge;
  logic                       ack_edge;
  logic                       needs_ac;
  logic                       bad_cmd;
  logic                       buf_in_valid;
  logic                       buf_in_ready;
  logic                       buf_out_valid;
  logic                       buf_out_ready;
  logic [PAYLOAD_W-1:0]       buf_out_data;
  gprc_kind_t                 out_kind;
  logic                       out_last;
  logic [BYTE_W-1:0]          out_byte;

  function automatic logic kind_is_command(input gprc_kind_t k);
    kind_is_command = (k == KIND_CMD) || (k == KIND_UNT);
  endfunction : kind_is_command

  // ----------------------------------------------------------------
  // command buffer
  // ----------------------------------------------------------------
  assign needs_ac     = kind_is_command(cmd_kind);
  assign bad_cmd      = needs_ac & ~is_active_ctrl;
  // a refused byte is still consumed so the host stream never hangs
  assign buf_in_valid = cmd_valid & ~bad_cmd;
  assign cmd_ready    = buf_in_ready;

  gprc_buf2 #(
    .W (PAYLOAD_W)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({cmd_kind, cmd_last, cmd_byte}),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  assign out_kind      = gprc_kind_t'(buf_out_data[PAYLOAD_W-1 -: KIND_W]);
  assign out_last      = buf_out_data[BYTE_W];
  assign out_byte      = buf_out_data[BYTE_W-1:0];
  assign buf_out_ready = (q.tx_st == TX_IDLE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign poll_edge = q.poll_s2 & ~q.poll_prev;
  assign ack_edge  = q.ack_s2 & ~q.ack_prev;

  always_comb begin
    d           = q;
    d.reject    = 1'b0;
    d.poll_s1   = poll_read_pin;
    d.poll_s2   = q.poll_s1;
    d.poll_prev = q.poll_s2;
    d.ack_s1    = bus_ack_pin;
    d.ack_s2    = q.ack_s1;
    d.ack_prev  = q.ack_s2;

    // poll response: a host load in the same cycle as a poll wins
    d.poll_drv = q.poll_s2 & is_peripheral;
    if (poll_edge && is_peripheral) begin
      d.dio              = q.resp;
      d.resp[RSV_BIT]    = 1'b0;
    end
    if (resp_load) begin
      d.resp = resp_value;
    end

    // status flags: a set in the reset cycle survives
    d.flag_chg = (q.flag_chg & ~warm_reset) | flag_change_set;
    d.flag_trg = (q.flag_trg & ~warm_reset) | flag_trigger_set;
    d.flag_clr = (q.flag_clr & ~warm_reset) | flag_clear_set;
    if (timeout_load) begin
      d.timeout = timeout_value;
    end

    // interface clear pulse
    if (q.ifc) begin
      if (q.ifc_cnt == IFC_LAST) begin
        d.ifc = 1'b0;
      end else begin
        d.ifc_cnt = q.ifc_cnt + 1'b1;
      end
    end

    // transmit engine
    if (q.tx_st == TX_IDLE) begin
      if (buf_out_valid) begin
        d.tx_st   = TX_SEND;
        d.tx_kind = out_kind;
        d.dio     = (out_kind == KIND_UNT) ? UNTALK_CODE : out_byte;
        d.atn     = kind_is_command(out_kind);
        d.eoi     = (out_kind == KIND_EOI) & out_last;
      end
    end else if (ack_edge) begin
      d.tx_st = TX_IDLE;
      d.eoi   = 1'b0;
    end

    // resume: refused while not controller or while bytes are pending
    if (resume_req) begin
      if (is_active_ctrl && q.tx_st == TX_IDLE && !buf_out_valid) begin
        d.atn = 1'b0;
      end else begin
        d.reject = 1'b1;
      end
    end
    if (cmd_valid && buf_in_ready && bad_cmd) begin
      d.reject = 1'b1;
    end

    // warm reset wins over timeout load and attention, and over a response load only on a peripheral; the flag sets win over it
    if (warm_reset) begin
      d.timeout = TIMEOUT_DEFAULT;
      d.atn     = 1'b0;
      if (is_peripheral) begin
        d.resp = RESP_DEFAULT;
      end
      if (is_sys_ctrl) begin
        d.ifc     = 1'b1;
        d.ifc_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.timeout <= TIMEOUT_DEFAULT;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign poll_response_value = q.resp;
  assign rsv_status          = q.resp[RSV_BIT];
  assign srq_out             = q.resp[RSV_BIT] & is_peripheral;
  assign flag_change         = q.flag_chg;
  assign flag_trigger        = q.flag_trg;
  assign flag_clear          = q.flag_clr;
  assign timeout_setting     = q.timeout;
  assign warm_busy           = q.ifc;
  assign ifc_out             = q.ifc;
  assign atn_out             = q.atn;
  assign eoi_out             = q.eoi;
  assign dav_out             = (q.tx_st == TX_SEND);
  assign dio_out             = q.dio;
  assign dio_oe              = q.poll_drv | (q.tx_st == TX_SEND);
  assign op_reject           = q.reject;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_poll_clears_rsv: assert property (@(posedge clk) disable iff (rst)
    poll_edge && is_peripheral && !resp_load && !warm_reset |=> !rsv_status)
    else $error("serial poll did not clear service bit");

  a_srq_follows_load: assert property (@(posedge clk) disable iff (rst)
    resp_load && resp_value[RSV_BIT] && !warm_reset ##1 is_peripheral |-> srq_out)
    else $error("service request not raised after load");

  a_srq_released: assert property (@(posedge clk) disable iff (rst)
    $fell(rsv_status) |-> !srq_out)
    else $error("service request held after bit cleared");

  a_poll_dio_value: assert property (@(posedge clk) disable iff (rst)
    poll_edge && is_peripheral && q.tx_st == TX_IDLE && !buf_out_valid
    |=> dio_out == $past(q.resp) ##1 dio_oe)
    else $error("poll byte not presented on data lines");

  a_ifc_width: assert property (@(posedge clk) disable iff (rst)
    $fell(ifc_out) && !$past(warm_reset) |-> $past(q.ifc_cnt) == IFC_LAST)
    else $error("interface clear ended early");

  a_reset_defaults: assert property (@(posedge clk) disable iff (rst)
    warm_reset |=> timeout_setting == TIMEOUT_DEFAULT && !flag_change == !$past(flag_change_set))
    else $error("warm reset defaults not restored");

  a_cmd_under_atn: assert property (@(posedge clk) disable iff (rst)
    dav_out && kind_is_command(q.tx_kind) |-> atn_out && !eoi_out)
    else $error("command byte sent without attention or with end");

  a_data_no_atn: assert property (@(posedge clk) disable iff (rst)
    dav_out && !kind_is_command(q.tx_kind) |-> !atn_out)
    else $error("data byte sent under attention");

  a_untalk_code: assert property (@(posedge clk) disable iff (rst)
    dav_out && q.tx_kind == KIND_UNT |-> dio_out == UNTALK_CODE)
    else $error("untalk byte wrong");

  // only an idle engine with no refused byte alongside gives a clean accept or refuse
  a_resume_refused: assert property (@(posedge clk) disable iff (rst)
    resume_req && !warm_reset && q.tx_st == TX_IDLE && !buf_out_valid && !(cmd_valid && bad_cmd)
    |=> op_reject == !$past(is_active_ctrl) && (!$past(is_active_ctrl) || !atn_out))
    else $error("resume not refused or accepted as expected");

  c_poll_seen:   cover property (@(posedge clk) disable iff (rst) poll_edge && rsv_status);
  c_ifc_pulse:   cover property (@(posedge clk) disable iff (rst) $fell(ifc_out));
  c_resume_done: cover property (@(posedge clk) disable iff (rst) $fell(atn_out) && !warm_reset);
  c_eoi_sent:    cover property (@(posedge clk) disable iff (rst) eoi_out && dav_out);

endmodule : gprc_top

`default_nettype wire

// ### verif/gprc_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

module gprc_bus_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // lines driven by the board
  input  wire logic       dav_out,
  input  wire logic [7:0] dio_out,
  input  wire logic       dio_oe,
  input  wire logic       atn_out,
  input  wire logic       eoi_out,
  // bench control
  input  wire logic [3:0] ack_wait,
  input  wire logic       poll_go,
  // lines driven by the far side
  output logic            bus_ack_pin,
  output logic            poll_read_pin,
  // what the far side saw
  output logic            rx_stb,
  output logic [7:0]      rx_byte,
  output logic            rx_atn,
  output logic            rx_eoi,
  output logic [7:0]      poll_byte,
  output logic [7:0]      poll_cnt
);
  logic [3:0] wait_q;
  logic [3:0] pin_q;
  logic       got_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {bus_ack_pin, poll_read_pin, rx_stb, rx_atn, rx_eoi, got_q} <= '0;
      {rx_byte, poll_byte, poll_cnt, wait_q, pin_q} <= '0;
    end else begin
      rx_stb <= 1'b0;
      // a slow listener holds off its accept, so the board's buffer must absorb the stall
      if (dav_out && !bus_ack_pin) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= ack_wait) begin
          bus_ack_pin <= 1'b1;
          rx_stb      <= 1'b1;
          rx_byte     <= dio_out;
          rx_atn      <= atn_out;
          rx_eoi      <= eoi_out;
          wait_q      <= 4'h0;
        end
      end else if (!dav_out) begin
        bus_ack_pin <= 1'b0;
      end
      // controller side of a serial poll: ten-cycle read window
      if (poll_go) begin
        poll_read_pin <= 1'b1;
        pin_q         <= 4'h0;
        got_q         <= 1'b0;
      end else if (poll_read_pin) begin
        pin_q <= pin_q + 4'h1;
        if (pin_q == 4'h9) poll_read_pin <= 1'b0;
        if (dio_oe && !got_q) begin
          got_q     <= 1'b1;
          poll_byte <= dio_out;
          poll_cnt  <= poll_cnt + 8'h01;
        end
      end
    end
  end

endmodule : gprc_bus_model

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module tb_top;
  import gprc_pkg::*;
  localparam int IFC_CYC = 8;
  logic clk = 1'b0, rst = 1'b1, is_peripheral = 1'b0, is_sys_ctrl = 1'b0, is_active_ctrl = 1'b0;
  logic resp_load = 1'b0, warm_reset = 1'b0, timeout_load = 1'b0, resume_req = 1'b0, poll_go = 1'b0;
  logic flag_change_set = 1'b0, flag_trigger_set = 1'b0, flag_clear_set = 1'b0;
  logic cmd_valid = 1'b0, cmd_last = 1'b0, saw_full = 1'b0;
  logic [7:0] resp_value = 8'h00, timeout_value = 8'h00, cmd_byte = 8'h00;
  logic [3:0] ack_wait = 4'h0;
  gprc_kind_t cmd_kind = KIND_CMD;
  logic cmd_ready, op_reject, rsv_status, warm_busy, ifc_out, atn_out, eoi_out, srq_out, dav_out, dio_oe;
  logic flag_change, flag_trigger, flag_clear, poll_read_pin, bus_ack_pin, rx_stb, rx_atn, rx_eoi;
  logic [7:0] poll_response_value, timeout_setting, dio_out, rx_byte, poll_byte, poll_cnt, v;
  logic [9:0] w;
  logic [9:0] exp_q[$];
  int err_total = 0, tests_run = 0, seed = 90, cyc = 0, n, r;

  always #10 clk = ~clk;

  // one board on this bench: the host drives this one gprc_top directly
  gprc_top #(.IFC_CYCLES(IFC_CYC)) dut_u (.clk, .rst, .is_peripheral, .is_sys_ctrl, .is_active_ctrl,
    .resp_load, .resp_value, .poll_response_value, .rsv_status, .warm_reset, .flag_change_set,
    .flag_trigger_set, .flag_clear_set, .timeout_load, .timeout_value, .flag_change, .flag_trigger,
    .flag_clear, .timeout_setting, .warm_busy, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_byte, .cmd_last,
    .resume_req, .op_reject, .ifc_out, .atn_out, .eoi_out, .srq_out, .dav_out, .dio_out, .dio_oe,
    .poll_read_pin, .bus_ack_pin);

  gprc_bus_model far_u (.clk, .rst, .dav_out, .dio_out, .dio_oe, .atn_out, .eoi_out, .ack_wait,
    .poll_go, .bus_ack_pin, .poll_read_pin, .rx_stb, .rx_byte, .rx_atn, .rx_eoi, .poll_byte, .poll_cnt);

  // expected {atn, eoi, byte} as the far side should see it
  function automatic logic [9:0] expect_word(input gprc_kind_t k, input logic [7:0] b, input logic l);
    logic atn;
    atn = (k == KIND_CMD) || (k == KIND_UNT);
    return {atn, (k == KIND_EOI) && l, (k == KIND_UNT) ? UNTALK_CODE : b};
  endfunction : expect_word

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  // leaves cmd_valid high so back-to-back sends never touch it twice in one step
  task automatic send(input gprc_kind_t k, input logic [7:0] b, input logic l);
    int i;
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_byte = b;
    cmd_last = l;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    #2;
    if (is_active_ctrl || k == KIND_DATA || k == KIND_EOI) exp_q.push_back(expect_word(k, b, l));
  endtask : send

  task automatic drain;
    int i;
    for (i = 0; i < 600 && (exp_q.size() != 0 || dav_out !== 1'b0); i++) tick(1);
    tick(4);
  endtask : drain

  always @(posedge clk) begin
    cyc++;
    if (cmd_valid && cmd_ready === 1'b0) saw_full = 1'b1;
    if (rx_stb === 1'b1) begin
      w = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
      `CHK("bus byte", w, {rx_atn, rx_eoi, rx_byte})
    end
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    tick(1);
    `CHK("timeout after reset", 8'h0A, timeout_setting)
    `CHK("srq after reset", 1'b0, srq_out)
    // -------------------------------------------------
    // poll response, host clear and serial poll
    // -------------------------------------------------
    is_peripheral = 1'b1;
    for (n = 0; n < 6; n++) begin
      v = 8'($random(seed));
      if (n < 2) v[6] = (n == 0);
      resp_value = v;
      pulse(resp_load);
      `CHK("stored response", v, poll_response_value)
      `CHK("srq level", v[6], srq_out)
      `CHK("rsv readback", v[6], rsv_status)
      if (n != 0) begin
        pulse(poll_go);
        tick(14);
        `CHK("poll byte", v, poll_byte)
        `CHK("poll count", 8'(n), poll_cnt)
        `CHK("rsv after poll", 1'b0, rsv_status)
        `CHK("srq after poll", 1'b0, srq_out)
        `CHK("response after poll", v & 8'hBF, poll_response_value)
      end
    end
    // -------------------------------------------------
    // warm reset as system controller
    // -------------------------------------------------
    is_sys_ctrl = 1'b1;
    resp_value = 8'hFF;
    timeout_value = 8'($random(seed));
    {flag_change_set, flag_trigger_set, flag_clear_set, timeout_load, resp_load} = 5'h1F;
    tick(1);
    {flag_change_set, flag_trigger_set, flag_clear_set, timeout_load, resp_load} = 5'h00;
    `CHK("flags set", 3'b111, {flag_change, flag_trigger, flag_clear})
    `CHK("timeout loaded", timeout_value, timeout_setting)
    `CHK("response before warm", 8'hFF, poll_response_value)
    pulse(warm_reset);
    `CHK("flags after warm", 3'b000, {flag_change, flag_trigger, flag_clear})
    `CHK("timeout after warm", 8'h0A, timeout_setting)
    `CHK("response after warm", 8'h00, poll_response_value)
    `CHK("busy with ifc", 1'b1, warm_busy)
    n = 0;
    while (ifc_out === 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
    `CHK("ifc width", IFC_CYC, n)
    // -------------------------------------------------
    // command stream as active controller, then a stall
    // -------------------------------------------------
    {is_peripheral, is_sys_ctrl, is_active_ctrl} = 3'b001;
    for (n = 0; n < 24; n++) begin
      r = $random(seed);
      if (n < 4) r[9:8] = n[1:0];
      if (n == 0) r[7:0] = 8'h20 + 8'(r[15:11] % 31);
      if (n == 3) r[10] = 1'b1;
      if (n == 12) ack_wait = 4'hC;
      send(gprc_kind_t'(r[9:8]), r[7:0], r[10]);
    end
    send(KIND_CMD, r[7:0], 1'b0);
    cmd_valid = 1'b0;
    drain();
    `CHK("buffer stall seen", 1'b1, saw_full)
    `CHK("atn held after cmd", 1'b1, atn_out)
    pulse(resume_req);
    `CHK("atn after resume", 1'b0, atn_out)
    `CHK("resume accepted", 1'b0, op_reject)
    // -------------------------------------------------
    // refusals when not active controller
    // -------------------------------------------------
    ack_wait = 4'h0;
    is_active_ctrl = 1'b0;
    for (n = 0; n < 2; n++) begin
      send(gprc_kind_t'(n[1:0]), 8'h3F, 1'b0);
      `CHK("command refused", 1'b1, op_reject)
      cmd_valid = 1'b0;
      tick(1);
    end
    pulse(resume_req);
    `CHK("resume refused", 1'b1, op_reject)
    // not a peripheral now: a poll must leave the data lines alone
    pulse(poll_go);
    tick(14);
    `CHK("poll ignored", 8'h05, poll_cnt)
    pulse(warm_reset);
    `CHK("no ifc off system controller", 1'b0, ifc_out)
    `CHK("timeout after second warm", 8'h0A, timeout_setting)
    send(KIND_DATA, 8'h5A, 1'b0);
    cmd_valid = 1'b0;
    drain();
    `CHK("bytes left over", 0, exp_q.size())
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
